/* diag_mux_pkg.sv */
// Shared constants and carriers for the diagnostic output port selector
package diag_mux_pkg;

  // Register byte addresses
  localparam logic [31:0] UPPER_SEL_ADDR = 32'h4000_020C; // Port 4..7 enables and selectors
  localparam logic [31:0] BIT_PICK_ADDR  = 32'h4000_0210; // Per-output bit index and invert

  // Reset values
  localparam logic [31:0] UPPER_SEL_RST = 32'h0000_0000;
  localparam logic [31:0] BIT_PICK_RST  = 32'h0000_0000;

  // Upper-select field layout: port p uses an 8-bit lane at (p-4)*8
  localparam int FIRST_UPPER_PORT = 4;   // Lowest port held in the upper register
  localparam int SEL_LANE_W       = 8;   // Lane stride per port
  localparam int SEL_LSB          = 0;   // Selector position within lane
  localparam int SEL_W            = 6;   // Selector width
  localparam int EN_POS           = 7;   // Enable position within lane
  // Reserved bits 30, 22, 14, 6 read as zero and are not stored
  localparam logic [31:0] UPPER_SEL_MASK = 32'hBFBF_BFBF;

  // Bit-pick field layout: output bit n uses a 4-bit group at 4n
  localparam int PICK_LANE_W = 4;        // Group stride per output bit
  localparam int IDX_LSB     = 0;        // Index position within group
  localparam int IDX_W       = 3;        // Index width
  localparam int INV_POS     = 3;        // Invert flag position within group

  // Port geometry
  localparam int NUM_PORTS = 8;          // Diagnostic port words and output bits

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  // Whole state of the selector
  typedef struct packed {
    logic [31:0]          upperSel;  // Enables and selectors, ports 4..7
    logic [31:0]          bitPick;   // Indices and invert flags, bits 0..7
    apb_rsp_t             rsp;       // Bus answer
    logic [NUM_PORTS-1:0] probeOut;  // Registered diagnostic output
  } mux_state_t;

endpackage

/* probe_capture.sv */
// Debug probe model that latches the diagnostic pins
module probe_capture (
  input  wire logic       clk,
  input  wire logic [7:0] probeOut,
  output      logic [7:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sample on the core edge, as a probe clocked by the core would
  always @(posedge clk) begin
    seen <= probeOut;
  end
endmodule

/* probe_word_mux.sv */
// One diagnostic port word: group select with enable gating
module probe_word_mux #(
  parameter int NUM_GROUPS = 64,
  parameter int GROUP_W    = 8
) (
  input  wire logic [NUM_GROUPS-1:0][GROUP_W-1:0] groupBus,
  input  wire logic [5:0]                         groupSel,
  input  wire logic                               portEn,
  output      logic [GROUP_W-1:0]                 portWord
);

  // Selector only matters while enabled; disabled word is all zero
  always_comb begin
    portWord = '0;
    if (portEn) begin
      portWord = groupBus[groupSel];
    end
  end

endmodule

/* radio_core_diag_port_mux.sv */
// Diagnostic output port selector with APB register access
// Notes on behaviour
// - Cleared enable forces port word to zero
// - Six-bit selector routes group onto port word
// - Selector ignored while its port is disabled
// - Three-bit index picks output bit from word
// - Invert flag complements the picked bit
// - Bit n group: invert 4n+3, index 4n+2:4n
module radio_core_diag_port_mux #(
  parameter int NUM_GROUPS = 64,   // Internal signal groups on offer
  parameter int GROUP_W    = 8     // Width of one group / port word
) (
  input  wire logic                               clk,
  input  wire logic                               resetn,
  input  wire logic                               ce,
  input  wire diag_mux_pkg::apb_req_t             apbReq,
  output      diag_mux_pkg::apb_rsp_t             apbRsp,
  input  wire logic [NUM_GROUPS-1:0][GROUP_W-1:0] groupBus,
  input  wire logic [3:0][5:0]                    lowerSel,
  input  wire logic [3:0]                         lowerEn,
  output      logic [7:0]                         probeOut
);

  // Geometry is fixed by the 6-bit selector and 3-bit index
  if (NUM_GROUPS != 64 || GROUP_W != 8) begin : g_bad_geometry
    $error("Selector needs 64 groups of 8 bits");
  end

  diag_mux_pkg::mux_state_t st_ff;   // Registered state
  diag_mux_pkg::mux_state_t nxt_st;  // Next state

  logic [7:0][GROUP_W-1:0] portWord; // Per-port selected words
  logic [7:0][5:0]         portSel;  // Per-port selector
  logic [7:0]              portEn;   // Per-port enable

  // One mux per port; lower ports are steered from outside
  for (genvar p = 0; p < diag_mux_pkg::NUM_PORTS; p++) begin : g_port
    if (p < diag_mux_pkg::FIRST_UPPER_PORT) begin : g_low
      assign portSel[p] = lowerSel[p];
      assign portEn[p]  = lowerEn[p];
    end else begin : g_up
      localparam int LANE = (p - diag_mux_pkg::FIRST_UPPER_PORT) * diag_mux_pkg::SEL_LANE_W;
      assign portSel[p] = st_ff.upperSel[LANE + diag_mux_pkg::SEL_LSB +:
                                         diag_mux_pkg::SEL_W];
      assign portEn[p]  = st_ff.upperSel[LANE + diag_mux_pkg::EN_POS];
    end
    // Zero gating and selection live in the word mux
    probe_word_mux #(
      .NUM_GROUPS (NUM_GROUPS),
      .GROUP_W    (GROUP_W)
    ) u_word (
      .groupBus (groupBus),
      .groupSel (portSel[p]),
      .portEn   (portEn[p]),
      .portWord (portWord[p])
    );
  end

  // Next-state logic: bus slave plus bit pick
  always_comb begin
    logic       accessPh;
    logic [2:0] idx;
    logic       inv;
    accessPh = 1'b0;
    idx      = 3'h0;
    inv      = 1'b0;
    nxt_st   = st_ff;
    accessPh = apbReq.psel && apbReq.penable;
    nxt_st.rsp.pready = 1'b0;
    // First access cycle: prepare answer, raise pready next cycle
    if (accessPh && !st_ff.rsp.pready) begin
      nxt_st.rsp.pready  = 1'b1;
      nxt_st.rsp.pslverr = 1'b0;
      nxt_st.rsp.prdata  = 32'h0000_0000;
      case (apbReq.paddr)
        diag_mux_pkg::UPPER_SEL_ADDR: nxt_st.rsp.prdata = st_ff.upperSel;
        diag_mux_pkg::BIT_PICK_ADDR:  nxt_st.rsp.prdata = st_ff.bitPick;
        default:                      nxt_st.rsp.pslverr = 1'b1; // Unmapped address
      endcase
    end
    // Completion edge: write lands only when pready is sampled high
    if (accessPh && st_ff.rsp.pready && apbReq.pwrite) begin
      case (apbReq.paddr)
        diag_mux_pkg::UPPER_SEL_ADDR:
          nxt_st.upperSel = apbReq.pwdata & diag_mux_pkg::UPPER_SEL_MASK;
        diag_mux_pkg::BIT_PICK_ADDR:
          nxt_st.bitPick = apbReq.pwdata;
        default: ; // Unmapped write ignored
      endcase
    end
    // Output bits: pick one bit of each port word, optional invert
    for (int n = 0; n < diag_mux_pkg::NUM_PORTS; n++) begin
      idx = st_ff.bitPick[n*diag_mux_pkg::PICK_LANE_W + diag_mux_pkg::IDX_LSB +:
                          diag_mux_pkg::IDX_W];
      inv = st_ff.bitPick[n*diag_mux_pkg::PICK_LANE_W + diag_mux_pkg::INV_POS];
      nxt_st.probeOut[n] = portWord[n][idx] ^ inv;
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff.upperSel <= diag_mux_pkg::UPPER_SEL_RST;
      st_ff.bitPick  <= diag_mux_pkg::BIT_PICK_RST;
      st_ff.rsp      <= '0;
      st_ff.probeOut <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flops
  assign apbRsp   = st_ff.rsp;
  assign probeOut = st_ff.probeOut;

  // Checks on the selector; registered output lags one enabled edge
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_en_gate;
    !st_ff.upperSel[31] |-> portWord[7] == '0;
  endproperty
  a_en_gate: assert property (p_en_gate) else $error("Disabled port 7 not zero");

  property p_sel_route;
    st_ff.upperSel[7] |-> portWord[4] == groupBus[st_ff.upperSel[5:0]];
  endproperty
  a_sel_route: assert property (p_sel_route) else $error("Port 4 wrong group");

  property p_sel_ignored;
    !st_ff.upperSel[15] && !$stable(st_ff.upperSel[13:8]) |-> portWord[5] == '0;
  endproperty
  a_sel_ignored: assert property (p_sel_ignored) else $error("Port 5 selector leaked");

  property p_bit_pick;
    ce |=> probeOut[0] == ($past(portWord[0][st_ff.bitPick[2:0]]) ^ $past(st_ff.bitPick[3]));
  endproperty
  a_bit_pick: assert property (p_bit_pick) else $error("Output bit 0 pick wrong");

  property p_invert;
    ce && st_ff.bitPick[31] |=> probeOut[7] != $past(portWord[7][st_ff.bitPick[30:28]]);
  endproperty
  a_invert: assert property (p_invert) else $error("Output bit 7 not inverted");

  property p_layout3;
    ce ##0 (st_ff.bitPick[15:12] == 4'h9) |=> probeOut[3] == !$past(portWord[3][1]);
  endproperty
  a_layout3: assert property (p_layout3) else $error("Bit 3 field layout wrong");

  property p_own_port;
    st_ff.upperSel[23] && !st_ff.upperSel[7] |-> portWord[6] == groupBus[st_ff.upperSel[21:16]]
                                                 && portWord[4] == '0;
  endproperty
  a_own_port: assert property (p_own_port) else $error("Enable gates wrong port");

  property p_apb_write;
    ce && apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite
      && apbReq.paddr == diag_mux_pkg::UPPER_SEL_ADDR
      |=> st_ff.upperSel == ($past(apbReq.pwdata) & diag_mux_pkg::UPPER_SEL_MASK);
  endproperty
  a_apb_write: assert property (p_apb_write) else $error("Select write lost");

  property p_wait_state;
    ce && apbReq.psel && apbReq.penable && !apbRsp.pready |=> apbRsp.pready;
  endproperty
  a_wait_state: assert property (p_wait_state) else $error("pready late");

  // Enable gating on the remaining upper ports
  property p_en_gate4;
    !st_ff.upperSel[7] |-> portWord[4] == '0;
  endproperty
  a_en_gate4: assert property (p_en_gate4) else $error("Disabled port 4 not zero");

  property p_en_gate5;
    !st_ff.upperSel[15] |-> portWord[5] == '0;
  endproperty
  a_en_gate5: assert property (p_en_gate5) else $error("Disabled port 5 not zero");

  property p_en_gate6;
    !st_ff.upperSel[23] |-> portWord[6] == '0;
  endproperty
  a_en_gate6: assert property (p_en_gate6) else $error("Disabled port 6 not zero");

  // Routing of the remaining upper ports
  property p_sel_route5;
    st_ff.upperSel[15] |-> portWord[5] == groupBus[st_ff.upperSel[13:8]];
  endproperty
  a_sel_route5: assert property (p_sel_route5) else $error("Port 5 wrong group");

  property p_sel_route6;
    st_ff.upperSel[23] |-> portWord[6] == groupBus[st_ff.upperSel[21:16]];
  endproperty
  a_sel_route6: assert property (p_sel_route6) else $error("Port 6 wrong group");

  property p_sel_route7;
    st_ff.upperSel[31] |-> portWord[7] == groupBus[st_ff.upperSel[29:24]];
  endproperty
  a_sel_route7: assert property (p_sel_route7) else $error("Port 7 wrong group");

  // Selector moves while disabled must not leak onto the word
  property p_sel_ignored4;
    !st_ff.upperSel[7] && !$stable(st_ff.upperSel[5:0]) |-> portWord[4] == '0;
  endproperty
  a_sel_ignored4: assert property (p_sel_ignored4) else $error("Port 4 selector leaked");

  property p_sel_ignored6;
    !st_ff.upperSel[23] && !$stable(st_ff.upperSel[21:16]) |-> portWord[6] == '0;
  endproperty
  a_sel_ignored6: assert property (p_sel_ignored6) else $error("Port 6 selector leaked");

  property p_sel_ignored7;
    !st_ff.upperSel[31] && !$stable(st_ff.upperSel[29:24]) |-> portWord[7] == '0;
  endproperty
  a_sel_ignored7: assert property (p_sel_ignored7) else $error("Port 7 selector leaked");

  // Lower ports follow their external enables and selectors
  property p_lower_gate0;
    !lowerEn[0] |-> portWord[0] == '0;
  endproperty
  a_lower_gate0: assert property (p_lower_gate0) else $error("Port 0 gate wrong");

  property p_lower_route1;
    lowerEn[1] |-> portWord[1] == groupBus[lowerSel[1]];
  endproperty
  a_lower_route1: assert property (p_lower_route1) else $error("Port 1 wrong group");

  // Bit pick on outputs 1 to 4, 6 and 7; each uses its own port word
  property p_bit_pick1;
    ce |=> probeOut[1] == $past(portWord[1][st_ff.bitPick[6:4]] ^ st_ff.bitPick[7]);
  endproperty
  a_bit_pick1: assert property (p_bit_pick1) else $error("Output bit 1 pick wrong");

  property p_bit_pick2;
    ce |=> probeOut[2] == $past(portWord[2][st_ff.bitPick[10:8]] ^ st_ff.bitPick[11]);
  endproperty
  a_bit_pick2: assert property (p_bit_pick2) else $error("Output bit 2 pick wrong");

  property p_bit_pick3;
    ce |=> probeOut[3] == $past(portWord[3][st_ff.bitPick[14:12]] ^ st_ff.bitPick[15]);
  endproperty
  a_bit_pick3: assert property (p_bit_pick3) else $error("Output bit 3 pick wrong");

  property p_bit_pick4;
    ce |=> probeOut[4] == $past(portWord[4][st_ff.bitPick[18:16]] ^ st_ff.bitPick[19]);
  endproperty
  a_bit_pick4: assert property (p_bit_pick4) else $error("Output bit 4 pick wrong");

  property p_bit_pick6;
    ce |=> probeOut[6] == $past(portWord[6][st_ff.bitPick[26:24]] ^ st_ff.bitPick[27]);
  endproperty
  a_bit_pick6: assert property (p_bit_pick6) else $error("Output bit 6 pick wrong");

  property p_bit_pick7;
    ce |=> probeOut[7] == $past(portWord[7][st_ff.bitPick[30:28]] ^ st_ff.bitPick[31]);
  endproperty
  a_bit_pick7: assert property (p_bit_pick7) else $error("Output bit 7 pick wrong");

  // Inversion on two more outputs
  property p_invert0;
    ce && st_ff.bitPick[3] |=> probeOut[0] != $past(portWord[0][st_ff.bitPick[2:0]]);
  endproperty
  a_invert0: assert property (p_invert0) else $error("Output bit 0 not inverted");

  property p_invert4;
    ce && st_ff.bitPick[19] |=> probeOut[4] != $past(portWord[4][st_ff.bitPick[18:16]]);
  endproperty
  a_invert4: assert property (p_invert4) else $error("Output bit 4 not inverted");

  // Bus side: reserved bits, error answer, read data, pulse, freeze
  property p_rsv_zero;
    (st_ff.upperSel & ~diag_mux_pkg::UPPER_SEL_MASK) == 32'h0000_0000;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("Reserved select bits set");

  property p_unmapped;
    ce && apbReq.psel && apbReq.penable && !apbRsp.pready
      && apbReq.paddr != diag_mux_pkg::UPPER_SEL_ADDR
      && apbReq.paddr != diag_mux_pkg::BIT_PICK_ADDR
      |=> apbRsp.pready && apbRsp.pslverr && apbRsp.prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped access not refused");

  property p_rd_pick;
    ce && apbReq.psel && apbReq.penable && !apbRsp.pready && !apbReq.pwrite
      && apbReq.paddr == diag_mux_pkg::BIT_PICK_ADDR
      |=> apbRsp.prdata == $past(st_ff.bitPick);
  endproperty
  a_rd_pick: assert property (p_rd_pick) else $error("Bit pick read wrong");

  property p_rd_upper;
    ce && apbReq.psel && apbReq.penable && !apbRsp.pready && !apbReq.pwrite
      && apbReq.paddr == diag_mux_pkg::UPPER_SEL_ADDR
      |=> apbRsp.prdata == $past(st_ff.upperSel);
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("Select read wrong");

  // A second pready would complete a transfer twice
  property p_ready_pulse;
    ce && apbRsp.pready |=> !apbRsp.pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");

  // Low enable must hold every bit of state, bus answer included
  property p_freeze;
    !ce |=> $stable(st_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved while frozen");

  c_enable7:  cover property (ce && st_ff.upperSel[31] && probeOut[7]);
  c_invert0:  cover property (ce && st_ff.bitPick[3] && probeOut[0]);
  c_slverr:   cover property (apbRsp.pready && apbRsp.pslverr);
  // Frozen cycle while the groups keep moving
  c_frozen:   cover property (!ce && !$stable(groupBus));
  c_rd_pick:  cover property (apbRsp.pready && !apbReq.pwrite
                              && apbReq.paddr == diag_mux_pkg::BIT_PICK_ADDR);

endmodule

/* testbench.sv */
// Self-checking bench for the diagnostic port selector
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk;        // 50 MHz clock
  logic                   resetn;     // Active-low reset
  logic                   ce;         // Clock enable
  diag_mux_pkg::apb_req_t req;        // Bus request
  diag_mux_pkg::apb_rsp_t rsp;        // Bus answer
  logic [63:0][7:0]       gb;         // Signal groups
  logic [3:0][5:0]        ls;         // Lower port selectors
  logic [3:0]             le;         // Lower port enables
  logic [7:0]             po;         // Diagnostic pins
  logic [7:0]             seen;       // Probe view of the pins
  logic [31:0]            rd;         // Read data or held value
  logic                   er;         // Error answer
  int                     err_count;  // Mismatches
  int                     checks;     // Comparisons
  // Configurations: all off, all on, selectors without enables, all on
  logic [31:0] upTab [4] = '{32'h0000_0000, 32'hBF95_8BA1, 32'h3F2A_1505, 32'h8081_FF9E};
  logic [31:0] pkTab [4] = '{32'h7654_3210, 32'hFEDC_BA98, 32'h0F1E_2D3C, 32'h89AB_CDEF};

  radio_core_diag_port_mux dut_u (.clk(clk), .resetn(resetn), .ce(ce), .apbReq(req),
    .apbRsp(rsp), .groupBus(gb), .lowerSel(ls), .lowerEn(le), .probeOut(po));
  probe_capture probe_u (.clk(clk), .probeOut(po), .seen(seen));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Prints counts and verdict, then stops
  task automatic complete_run();
    $display("Counts: checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One transfer; request held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    req <= '0;
    rd = rsp.prdata;
    er = rsp.pslverr;
    // A slave that never answers ends the run
    if (n >= 20) begin
      err_count++;
      complete_run();
    end
  endtask

  // Expected pins for given register values and the current groups
  function automatic logic [7:0] expo(input logic [31:0] u, input logic [31:0] p);
    logic [7:0] w;
    logic [7:0] o;
    for (int n = 0; n < 8; n++) begin
      if (n < 4) begin
        w = le[n] ? gb[ls[n]] : 8'h00;
      end else begin
        w = u[8*(n-4)+7] ? gb[u[8*(n-4)+:6]] : 8'h00;
      end
      o[n] = w[p[4*n+:3]] ^ p[4*n+3];
    end
    return o;
  endfunction

  // Main sequence
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    req = '0;
    le = 4'h0;
    ls = '0;
    err_count = 0;
    checks = 0;
    // Distinct pattern per group so a wrong pick shows
    for (int g = 0; g < 64; g++) begin
      gb[g] = 8'(g * 29 + 3);
    end
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    // Both registers leave reset cleared
    xfer(1'b0, diag_mux_pkg::UPPER_SEL_ADDR, '0);
    `CHK(rd, 32'h0000_0000)
    xfer(1'b0, diag_mux_pkg::BIT_PICK_ADDR, '0);
    `CHK(rd, 32'h0000_0000)
    // Reserved bits read back as zero
    xfer(1'b1, diag_mux_pkg::UPPER_SEL_ADDR, 32'hFFFF_FFFF);
    xfer(1'b0, diag_mux_pkg::UPPER_SEL_ADDR, '0);
    `CHK(rd, 32'hBFBF_BFBF)
    // Unmapped word answers with an error
    xfer(1'b1, 32'h4000_0214, 32'h1234_5678);
    `CHK(er, 1'b1)
    // Walk the configurations, lower ports varied alongside
    for (int i = 0; i < 4; i++) begin
      le <= 4'(i * 5);
      ls <= {6'(i + 7), 6'(i * 9), 6'h3F, 6'(i)};
      xfer(1'b1, diag_mux_pkg::UPPER_SEL_ADDR, upTab[i]);
      xfer(1'b1, diag_mux_pkg::BIT_PICK_ADDR, pkTab[i]);
      xfer(1'b0, diag_mux_pkg::BIT_PICK_ADDR, '0);
      `CHK(rd, pkTab[i])
      repeat (3) @(posedge clk);
      `CHK(seen, expo(upTab[i], pkTab[i]))
    end
    // Frozen enable holds the pins while the groups move
    rd = {24'h0, expo(upTab[3], pkTab[3])};
    ce <= 1'b0;
    gb <= ~gb;
    repeat (3) @(posedge clk);
    `CHK(seen, rd[7:0])
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(seen, expo(upTab[3], pkTab[3]))
    complete_run();
  end
endmodule
